/* pkg/wrt_pkg.sv */
// constants and types of the reloadable watchdog timer
// assumes one system clock; the watchdog oscillator arrives as a sampled level

package wrt_pkg;

  localparam logic [11:0] WRT_ADDR_RELOAD_HIGH = 12'hff2;
  localparam logic [11:0] WRT_ADDR_RELOAD_LOW = 12'hff3;

  localparam logic [7:0] WRT_RELOAD_HIGH_RST = 8'h04;
  localparam logic [7:0] WRT_RELOAD_LOW_RST = 8'h00;
  localparam logic [15:0] WRT_COUNT_RST = 16'h0400;
  localparam logic [15:0] WRT_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] WRT_COUNT_ONE = 16'h0001;
  localparam logic [7:0] WRT_RDATA_RST = 8'h00;
  localparam logic [12:0] WRT_MS_RST = 13'h0066;

  localparam logic [7:0] WRT_UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] WRT_UNLOCK_KEY2 = 8'haa;

  // typical oscillator rate and the divisor giving milliseconds
  localparam int WRT_OSC_FREQ_HZ = 8200;
  localparam logic [15:0] WRT_MS_DIVISOR = 16'h000a;

  typedef enum logic [3:0] {
    WRT_LOCKED    = 4'b0001,
    WRT_KEY1_SEEN = 4'b0010,
    WRT_OPEN      = 4'b0100,
    WRT_HIGH_DONE = 4'b1000
  } wrt_unlock_t;

  typedef enum logic [2:0] {
    WRT_OFF    = 3'b001,
    WRT_RUN    = 3'b010,
    WRT_HALTED = 3'b100
  } wrt_run_t;

  function automatic logic [12:0] wrt_nominal_ms(input logic [15:0] reload);
    logic [15:0] quot;
    quot = reload / WRT_MS_DIVISOR;
    return quot[12:0];
  endfunction

endpackage

/* rtl/wrt_osc_tick.sv */
// edge detector turning the watchdog oscillator level into one-cycle ticks
// assumes the oscillator level is already synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none

module wrt_osc_tick (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic osc_level,
  output logic tick
);
  import wrt_pkg::*;

  logic osc_prev_q;
  logic tick_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_level;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= osc_level & ~osc_prev_q;
    end
  end

  assign tick = tick_q;

endmodule // wrt_osc_tick

`default_nettype wire

/* rtl/wrt_unlock.sv */
// unlock tracker guarding the two reload registers
// assumes writes arrive as one-cycle strobes with the address already decoded
`timescale 1ns/100ps
`default_nettype none

module wrt_unlock (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  output logic load_high,
  output logic load_low,
  output logic unlocked
);
  import wrt_pkg::*;

  wrt_unlock_t state_q;
  wrt_unlock_t state_d;

  always_comb begin
    state_d = state_q;
    load_high = 1'b0;
    load_low = 1'b0;
    unique case (state_q)
      WRT_LOCKED: begin
        if (wr_high && wdata == WRT_UNLOCK_KEY1) begin
          state_d = WRT_KEY1_SEEN;
        end
      end
      WRT_KEY1_SEEN: begin
        if (wr_high && wdata == WRT_UNLOCK_KEY2) begin
          state_d = WRT_OPEN;
        end else if (wr_high || wr_low) begin
          state_d = WRT_LOCKED;
        end
      end
      WRT_OPEN: begin
        if (wr_high) begin
          load_high = 1'b1;
          state_d = WRT_HIGH_DONE;
        end else if (wr_low) begin
          state_d = WRT_LOCKED;
        end
      end
      WRT_HIGH_DONE: begin
        if (wr_low) begin
          load_low = 1'b1;
          state_d = WRT_LOCKED;
        end else if (wr_high) begin
          state_d = WRT_LOCKED;
        end
      end
      default: begin
        state_d = WRT_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= WRT_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  // next-state decode, so the registered copy upstream tracks state_q without lag
  assign unlocked = (state_d == WRT_OPEN) || (state_d == WRT_HIGH_DONE);

endmodule // wrt_unlock

`default_nettype wire

/* rtl/wrt_watchdog.sv */
// reloadable 16-bit watchdog: reload registers, down-counter, time-out response
// assumes byte-wide register strobes from the cpu and option bits held stable
`timescale 1ns/100ps
`default_nettype none

module wrt_watchdog (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic retrigger,
  input wire logic watchdog_oscillator,
  input wire logic always_on_option,
  input wire logic timeout_response_option,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic watchdog_flag_clear,
  input wire logic stop_flag_clear,
  output logic irq_req,
  output logic sys_reset_req,
  output logic stop_recovery,
  output logic watchdog_flag,
  output logic stop_flag,
  output logic enabled,
  output logic reload_unlocked,
  output logic [15:0] count,
  output logic [12:0] nominal_timeout_ms
);
  import wrt_pkg::*;

  logic osc_tick;
  logic wr_high;
  logic wr_low;
  logic load_high;
  logic load_low;
  logic unlocked;
  logic enable_now;
  logic reload_now;
  logic timeout_hit;
  logic resp_reset;
  logic [15:0] reload_val;

  logic [7:0] reload_high_q;
  logic [7:0] reload_low_q;
  wrt_run_t run_q;
  logic [15:0] count_q;
  logic timeout_pend_q;
  logic irq_req_q;
  logic sys_reset_req_q;
  logic stop_recovery_q;
  logic watchdog_flag_q;
  logic stop_flag_q;
  logic unlocked_q;
  logic [7:0] reg_rdata_q;
  logic [12:0] nominal_ms_q;

  function automatic logic [7:0] count_byte(input logic [15:0] cnt, input logic high);
    return high ? cnt[15:8] : cnt[7:0];
  endfunction

  wrt_osc_tick u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .osc_level(watchdog_oscillator),
    .tick(osc_tick)
  );

  assign wr_high = reg_wr && (reg_addr == WRT_ADDR_RELOAD_HIGH);
  assign wr_low = reg_wr && (reg_addr == WRT_ADDR_RELOAD_LOW);

  wrt_unlock u_unlock (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_high(wr_high),
    .wr_low(wr_low),
    .wdata(reg_wdata),
    .load_high(load_high),
    .load_low(load_low),
    .unlocked(unlocked)
  );

  // reload value as high and low byte
  assign reload_val = {reload_high_q, reload_low_q};

  // option set to one selects the system reset response
  assign resp_reset = timeout_response_option;

  // switched on by retrigger or option low
  assign enable_now = (run_q == WRT_OFF) && (retrigger || !always_on_option);

  // retrigger reloads; debug holds it reloaded
  assign reload_now = (run_q == WRT_RUN) && (retrigger || debug_mode);

  // time-out when the count reaches zero
  assign timeout_hit = (run_q == WRT_RUN) && osc_tick && !reload_now
    && (count_q <= WRT_COUNT_ONE);

  // only unlocked writes change the bytes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reload_high_q <= WRT_RELOAD_HIGH_RST;
    end else if (load_high) begin
      reload_high_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reload_low_q <= WRT_RELOAD_LOW_RST;
    end else if (load_low) begin
      reload_low_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= WRT_OFF;
    end else begin
      unique case (run_q)
        WRT_OFF: begin
          if (enable_now) begin
            run_q <= WRT_RUN;
          end
        end
        WRT_RUN: begin
          if (timeout_pend_q && resp_reset && !stop_mode) begin
            run_q <= WRT_HALTED;
          end
        end
        WRT_HALTED: begin
          run_q <= WRT_HALTED;
        end
        default: begin
          run_q <= WRT_OFF;
        end
      endcase
    end
  end

  // counter restarts from the reload value
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= WRT_COUNT_RST;
    end else if (enable_now) begin
      count_q <= reload_val;
    end else if (run_q != WRT_RUN) begin
      count_q <= count_q;
    end else if (reload_now) begin
      count_q <= reload_val;
    end else if (timeout_pend_q && !(resp_reset && !stop_mode)) begin
      count_q <= reload_val;
    end else if (timeout_hit) begin
      count_q <= WRT_COUNT_ZERO;
    end else if (osc_tick && !timeout_pend_q) begin
      count_q <= count_q - WRT_COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timeout_pend_q <= 1'b0;
    end else begin
      timeout_pend_q <= timeout_hit;
    end
  end

  // interrupt in active or halt; also in stop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= timeout_pend_q && !resp_reset;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_req_q <= 1'b0;
    end else if (timeout_pend_q && resp_reset && !stop_mode) begin
      sys_reset_req_q <= 1'b1;
    end
  end

  // stop mode time-out wakes the part
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stop_recovery_q <= 1'b0;
    end else begin
      stop_recovery_q <= timeout_pend_q && stop_mode;
    end
  end

  // software clear; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_flag_q <= 1'b0;
    end else if (timeout_pend_q) begin
      watchdog_flag_q <= 1'b1;
    end else if (watchdog_flag_clear) begin
      watchdog_flag_q <= 1'b0;
    end
  end

  // stop flag with the watchdog flag
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stop_flag_q <= 1'b0;
    end else if (timeout_pend_q && stop_mode) begin
      stop_flag_q <= 1'b1;
    end else if (stop_flag_clear) begin
      stop_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unlocked_q <= 1'b0;
    end else begin
      unlocked_q <= unlocked;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= WRT_RDATA_RST;
    end else if (reg_rd && reg_addr == WRT_ADDR_RELOAD_HIGH) begin
      reg_rdata_q <= count_byte(count_q, 1'b1);
    end else if (reg_rd && reg_addr == WRT_ADDR_RELOAD_LOW) begin
      reg_rdata_q <= count_byte(count_q, 1'b0);
    end else if (reg_rd) begin
      reg_rdata_q <= WRT_RDATA_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nominal_ms_q <= WRT_MS_RST;
    end else begin
      nominal_ms_q <= wrt_nominal_ms(reload_val);
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign irq_req = irq_req_q;
  assign sys_reset_req = sys_reset_req_q;
  assign stop_recovery = stop_recovery_q;
  assign watchdog_flag = watchdog_flag_q;
  assign stop_flag = stop_flag_q;
  assign enabled = (run_q != WRT_OFF);
  assign reload_unlocked = unlocked_q;
  assign count = count_q;
  assign nominal_timeout_ms = nominal_ms_q;

endmodule // wrt_watchdog

`default_nettype wire

/* testbench/wrt_cpu_model.sv */
// far side model: watchdog oscillator source and software flag clearing
// assumes clk_sys from the bench; ack asks software to clear both flags
`timescale 1ns/100ps
`default_nettype none

module wrt_cpu_model #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic ack,
  input wire logic watchdog_flag,
  input wire logic stop_flag,
  output logic watchdog_oscillator,
  output logic watchdog_flag_clear,
  output logic stop_flag_clear
);
  int ph = 0;
  initial watchdog_oscillator = 1'b0;
  initial watchdog_flag_clear = 1'b0;
  initial stop_flag_clear = 1'b0;
  always @(posedge clk_sys) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      watchdog_oscillator <= !watchdog_oscillator;
    end
  end
  always @(posedge clk_sys) begin
    watchdog_flag_clear <= ack && watchdog_flag;
    stop_flag_clear <= ack && stop_flag;
  end
endmodule // wrt_cpu_model
`default_nettype wire

/* testbench/wrt_watchdog_assertions.sv */
// assertions on the watchdog top module ports
// assumes one clk_sys domain with rst_b active low
`timescale 1ns/100ps
`default_nettype none

module wrt_watchdog_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic always_on_option,
  input wire logic debug_mode,
  input wire logic irq_req,
  input wire logic sys_reset_req,
  input wire logic stop_recovery,
  input wire logic watchdog_flag,
  input wire logic stop_flag,
  input wire logic enabled,
  input wire logic reload_unlocked,
  input wire logic [15:0] count
);
  import wrt_pkg::*;
  logic [15:0] cnt_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) cnt_q <= WRT_COUNT_RST;
    else cnt_q <= count;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence key1_s;
    reg_wr && reg_addr == WRT_ADDR_RELOAD_HIGH && reg_wdata == WRT_UNLOCK_KEY1 && !reload_unlocked;
  endsequence
  sequence key2_s;
    reg_wr && reg_addr == WRT_ADDR_RELOAD_HIGH && reg_wdata == WRT_UNLOCK_KEY2;
  endsequence
  chk_unlock_keys: assert property (key1_s ##2 key2_s |=> reload_unlocked)
    else $error("unlock keys did not open reload");
  chk_low_relocks: assert property (reg_wr && reg_addr == WRT_ADDR_RELOAD_LOW |=> !reload_unlocked)
    else $error("low write did not relock");
  chk_read_live: assert property (reg_rd && reg_addr == WRT_ADDR_RELOAD_HIGH |=> reg_rdata == cnt_q[15:8])
    else $error("high read not live count");
  chk_irq_at_zero: assert property (irq_req |-> cnt_q == WRT_COUNT_ZERO && watchdog_flag)
    else $error("irq without zero count or flag");
  chk_irq_pulse: assert property (irq_req |=> !irq_req)
    else $error("irq longer than one cycle");
  chk_stop_flags: assert property (stop_recovery |-> watchdog_flag && stop_flag)
    else $error("stop recovery without both flags");
  chk_reset_hold: assert property (sys_reset_req |=> sys_reset_req && $stable(count))
    else $error("reset request dropped or count moved");
  chk_debug_hold: assert property (debug_mode [*3] |-> $stable(count))
    else $error("count moved in debug");
  chk_always_on: assert property (!always_on_option |=> enabled)
    else $error("always on option did not enable");
  chk_stays_on: assert property (enabled |=> enabled)
    else $error("watchdog switched off");
endmodule // wrt_watchdog_checker

bind wrt_watchdog wrt_watchdog_checker wrt_watchdog_checker_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .always_on_option(always_on_option), .debug_mode(debug_mode), .irq_req(irq_req),
  .sys_reset_req(sys_reset_req), .stop_recovery(stop_recovery),
  .watchdog_flag(watchdog_flag), .stop_flag(stop_flag), .enabled(enabled),
  .reload_unlocked(reload_unlocked), .count(count)
);
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the reloadable watchdog
// assumes wrt_pkg compiled first and the checker bound to the top module
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import wrt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic retrigger = 1'b0;
  logic always_on_option = 1'b1;
  logic timeout_response_option = 1'b0;
  logic debug_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic ack = 1'b0;
  logic osc, wclr, sclr, irq_req, sys_reset_req, stop_recovery, watchdog_flag, stop_flag;
  logic enabled, reload_unlocked;
  logic [7:0] reg_rdata;
  logic [15:0] count;
  logic [12:0] ms;
  logic [2:0] ev;
  int miscompares = 0;
  int n_tests = 0;
  assign ev = {sys_reset_req, stop_recovery, irq_req};
  always #2 clk_sys = ~clk_sys;

  wrt_watchdog wrt_watchdog_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .retrigger(retrigger), .watchdog_oscillator(osc), .always_on_option(always_on_option),
    .timeout_response_option(timeout_response_option), .debug_mode(debug_mode),
    .stop_mode(stop_mode), .watchdog_flag_clear(wclr), .stop_flag_clear(sclr),
    .irq_req(irq_req), .sys_reset_req(sys_reset_req), .stop_recovery(stop_recovery),
    .watchdog_flag(watchdog_flag), .stop_flag(stop_flag), .enabled(enabled),
    .reload_unlocked(reload_unlocked), .count(count), .nominal_timeout_ms(ms));
  wrt_cpu_model wrt_cpu_model_inst (.clk_sys(clk_sys), .ack(ack),
    .watchdog_flag(watchdog_flag), .stop_flag(stop_flag), .watchdog_oscillator(osc),
    .watchdog_flag_clear(wclr), .stop_flag_clear(sclr));

  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic kick;
    @(posedge clk_sys);
    retrigger <= 1'b1;
    @(posedge clk_sys);
    retrigger <= 1'b0;
    #1;
  endtask
  task automatic wait_ev(input int k);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if (ev[k] === 1'b1) return;
    end
    miscompares++;
    $display("ERROR event %0d expected 1 seen 0", k);
    tally_and_finish;
  endtask
  task automatic clear_flags;
    ack <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ack <= 1'b0;
    #1;
    chk("flags cleared", 16'h0000, {14'h0, watchdog_flag, stop_flag});
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk("count", WRT_COUNT_RST, count);
    chk("ms", {3'h0, WRT_MS_RST}, {3'h0, ms});
    chk("enabled", 16'h0000, {15'h0, enabled});
    rd(WRT_ADDR_RELOAD_HIGH, WRT_RELOAD_HIGH_RST, "rd high");
    rd(WRT_ADDR_RELOAD_LOW, WRT_RELOAD_LOW_RST, "rd low");
    rd(12'hff0, 8'h00, "rd unmapped");
    wr(WRT_ADDR_RELOAD_HIGH, 8'h12);
    wr(WRT_ADDR_RELOAD_LOW, 8'h34);
    wr(WRT_ADDR_RELOAD_HIGH, WRT_UNLOCK_KEY1);
    wr(WRT_ADDR_RELOAD_LOW, 8'h77);
    wr(WRT_ADDR_RELOAD_HIGH, WRT_UNLOCK_KEY2);
    chk("out of order", 16'h0000, {15'h0, reload_unlocked});
    wr(WRT_ADDR_RELOAD_HIGH, WRT_UNLOCK_KEY1);
    wr(WRT_ADDR_RELOAD_HIGH, WRT_UNLOCK_KEY2);
    chk("unlocked", 16'h0001, {15'h0, reload_unlocked});
    wr(WRT_ADDR_RELOAD_HIGH, 8'h00);
    wr(WRT_ADDR_RELOAD_LOW, 8'h14);
    chk("relocked", 16'h0000, {15'h0, reload_unlocked});
    wr(WRT_ADDR_RELOAD_HIGH, 8'h12);
    chk("ms new", 16'h0002, {3'h0, ms});
    kick();
    chk("kick count", 16'h0014, count);
    chk("kick on", 16'h0001, {15'h0, enabled});
    wait_ev(0);
    chk("irq reload", 16'h0014, count);
    chk("irq flags", 16'h0002, {14'h0, watchdog_flag, stop_flag});
    clear_flags();
    stop_mode <= 1'b1;
    wait_ev(1);
    chk("stop irq", 16'h0007, {13'h0, irq_req, watchdog_flag, stop_flag});
    chk("stop reload", 16'h0014, count);
    clear_flags();
    debug_mode <= 1'b1;
    repeat (300) @(posedge clk_sys);
    #1;
    chk("debug count", 16'h0014, count);
    chk("debug flag", 16'h0000, {15'h0, watchdog_flag});
    debug_mode <= 1'b0;
    timeout_response_option <= 1'b1;
    wait_ev(1);
    chk("stop no reset", 16'h0003, {14'h0, sys_reset_req, watchdog_flag, stop_flag});
    clear_flags();
    stop_mode <= 1'b0;
    wait_ev(2);
    chk("reset flag", 16'h0001, {15'h0, watchdog_flag});
    repeat (20) @(posedge clk_sys);
    rd(WRT_ADDR_RELOAD_LOW, 8'h00, "rd frozen");
    rst_b <= 1'b0;
    always_on_option <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("reinit count", WRT_COUNT_RST, count);
    chk("always on", 16'h0001, {15'h0, enabled});
    repeat (40) @(posedge clk_sys);
    #1;
    chk("counting", 16'h0001, {15'h0, count < WRT_COUNT_RST});
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
